// >>> hdl/dmr_bank.v
// Read-only readback bank for the diagnostic converter's monitor results.
// ==========================================================================
// ==========================================================================
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defs.vh"

module dmr_bank #(
    parameter RESULT_W = `DMR_RESULT_W,
    parameter SOURCES  = `DMR_SOURCES
) (
    input  wire                clk,
    input  wire                resetn,
    input  wire                resultValid,
    input  wire [3:0]          resultTag,
    input  wire [RESULT_W-1:0] resultData,
    input  wire                freezeResultUpdate,
    input  wire                regRead,
    input  wire                regWrite,
    input  wire [7:0]          regAddr,
    input  wire [7:0]          regWdata,
    output reg  [7:0]          regRdata,
    output reg                 regRvalid,
    output reg                 regHit
);

    // ======================================================================
    // Per-source result holders
    // ======================================================================
    wire [RESULT_W*SOURCES-1:0] heldFlat;
    wire [RESULT_W-1:0]         biasResult;
    wire [RESULT_W-1:0]         in1pResult;
    wire [RESULT_W-1:0]         in1nResult;
    wire [RESULT_W-1:0]         in2pResult;
    wire [RESULT_W-1:0]         in2nResult;
    wire [RESULT_W-1:0]         in3pResult;

    genvar gi;
    generate
        for (gi = 0; gi < SOURCES; gi = gi + 1) begin : gSource
            localparam integer TAG_NUM = gi + 1;
            wire               hitTag;
            // Tags start at one; slot zero of the tag space carries no source.
            assign hitTag = resultValid && (resultTag == TAG_NUM[3:0]);
            dmr_result_latch #(
                .WIDTH (RESULT_W)
            ) uLatch (
                .clk     (clk),
                .resetn  (resetn),
                .capture (hitTag),
                .freeze  (freezeResultUpdate),
                .dataIn  (resultData),
                .dataOut (heldFlat[gi*RESULT_W +: RESULT_W])
            );
        end
    endgenerate

    assign biasResult = heldFlat[0*RESULT_W +: RESULT_W];
    assign in1pResult = heldFlat[1*RESULT_W +: RESULT_W];
    assign in1nResult = heldFlat[2*RESULT_W +: RESULT_W];
    assign in2pResult = heldFlat[3*RESULT_W +: RESULT_W];
    assign in2nResult = heldFlat[4*RESULT_W +: RESULT_W];
    assign in3pResult = heldFlat[5*RESULT_W +: RESULT_W];

    // ======================================================================
    // Register images
    // ======================================================================
    wire [7:0] biasLow;
    wire [7:0] in1pHigh;
    wire [7:0] in1pLow;
    wire [7:0] in1nHigh;
    wire [7:0] in1nLow;
    wire [7:0] in2pHigh;
    wire [7:0] in2pLow;
    wire [7:0] in2nHigh;
    wire [7:0] in2nLow;
    wire [7:0] in3pHigh;
    wire [7:0] in3pLow;

    assign biasLow  = {biasResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_BIAS};
    assign in1pHigh = in1pResult[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
    assign in1pLow  = {in1pResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_INPUT1_POS};
    assign in1nHigh = in1nResult[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
    assign in1nLow  = {in1nResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_IN1N};
    assign in2pHigh = in2pResult[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
    assign in2pLow  = {in2pResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_INPUT2_POS};
    assign in2nHigh = in2nResult[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
    assign in2nLow  = {in2nResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_IN2N};
    assign in3pHigh = in3pResult[`DMR_HIGH_MSB:`DMR_HIGH_LSB];
    assign in3pLow  = {in3pResult[`DMR_NIBBLE_MSB:`DMR_NIBBLE_LSB], `DMR_TAG_INPUT3_POS};

    // ======================================================================
    // Address decode
    // ======================================================================
    reg [7:0] readData_d;
    reg       hit_d;

    always @* begin
        readData_d = `DMR_READ_NONE;
        hit_d      = 1'b1;
        if (regAddr == `DMR_OFS_BIAS_LOW) begin
            readData_d = biasLow;
        // high byte below its low register
        end else if (regAddr == `DMR_OFS_INPUT1_POS_HIGH) begin
            readData_d = in1pHigh;
        end else if (regAddr == `DMR_OFS_INPUT1_POS_LOW) begin
            readData_d = in1pLow;
        end else if (regAddr == `DMR_OFS_IN1N_HIGH) begin
            readData_d = in1nHigh;
        end else if (regAddr == `DMR_OFS_IN1N_LOW) begin
            readData_d = in1nLow;
        end else if (regAddr == `DMR_OFS_INPUT2_POS_HIGH) begin
            readData_d = in2pHigh;
        end else if (regAddr == `DMR_OFS_INPUT2_POS_LOW) begin
            readData_d = in2pLow;
        end else if (regAddr == `DMR_OFS_IN2N_HIGH) begin
            readData_d = in2nHigh;
        end else if (regAddr == `DMR_OFS_IN2N_LOW) begin
            readData_d = in2nLow;
        end else if (regAddr == `DMR_OFS_INPUT3_POS_HIGH) begin
            readData_d = in3pHigh;
        end else if (regAddr == `DMR_OFS_INPUT3_POS_LOW) begin
            readData_d = in3pLow;
        end else begin
            hit_d = 1'b0;
        end
    end

    // ======================================================================
    // Read port
    // ======================================================================
    // The high byte and the low nibble are separate reads, so a result that
    // lands between them tears the pair unless software freezes updates.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata  <= `DMR_READ_NONE;
            regRvalid <= 1'b0;
            regHit    <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= readData_d;
                regHit   <= hit_d;
            end else if (regWrite) begin
                regHit   <= hit_d;
            end
        end
    end

    // Write data is accepted on the port and discarded; nothing here stores it.
    wire unusedWrite;
    assign unusedWrite = ^regWdata;

endmodule // dmr_bank

`default_nettype wire

// >>> common/dmr_defs.vh
// Offsets, field positions, source tags and reset values of the monitor readback bank.
`ifndef DMR_DEFS_VH
`define DMR_DEFS_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define DMR_OFS_BIAS_LOW      8'h5d
`define DMR_OFS_INPUT1_POS_HIGH     8'h5e
`define DMR_OFS_INPUT1_POS_LOW      8'h5f
`define DMR_OFS_IN1N_HIGH     8'h60
`define DMR_OFS_IN1N_LOW      8'h61
`define DMR_OFS_INPUT2_POS_HIGH     8'h62
`define DMR_OFS_INPUT2_POS_LOW      8'h63
`define DMR_OFS_IN2N_HIGH     8'h64
`define DMR_OFS_IN2N_LOW      8'h65
`define DMR_OFS_INPUT3_POS_HIGH     8'h66
`define DMR_OFS_INPUT3_POS_LOW      8'h67

// ==========================================================================
// Field positions
// ==========================================================================
`define DMR_RESULT_W          12
`define DMR_HIGH_MSB          11
`define DMR_HIGH_LSB          4
`define DMR_NIBBLE_MSB        3
`define DMR_NIBBLE_LSB        0
`define DMR_TAG_W             4

// ==========================================================================
// Source tags and reset values
// ==========================================================================
`define DMR_TAG_BIAS          4'h1
`define DMR_TAG_INPUT1_POS          4'h2
`define DMR_TAG_IN1N          4'h3
`define DMR_TAG_INPUT2_POS          4'h4
`define DMR_TAG_IN2N          4'h5
`define DMR_TAG_INPUT3_POS          4'h6
`define DMR_SOURCES           6
`define DMR_RESULT_RESET      12'h000
`define DMR_READ_NONE         8'h00

`endif

// >>> hdl/dmr_result_latch.v
// One monitor result holder with freeze and a pending slot for the latest result.
`timescale 1ns/1ps
`default_nettype none

module dmr_result_latch #(
    parameter WIDTH = 12
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             capture,
    input  wire             freeze,
    input  wire [WIDTH-1:0] dataIn,
    output reg  [WIDTH-1:0] dataOut
);

    reg [WIDTH-1:0] pending_q;
    reg             pendingValid_q;

    // ======================================================================
    // Update and freeze
    // ======================================================================
    // While frozen the newest result waits in the pending slot and moves out on the first edge after the release,
    // unless a capture on that edge replaces it, so a read in that same cycle still shows the older result.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dataOut        <= {WIDTH{1'b0}};
            pending_q      <= {WIDTH{1'b0}};
            pendingValid_q <= 1'b0;
        end else if (freeze) begin
            if (capture) begin
                pending_q      <= dataIn;
                pendingValid_q <= 1'b1;
            end
        end else if (capture) begin
            dataOut        <= dataIn;
            pendingValid_q <= 1'b0;
        end else if (pendingValid_q) begin
            dataOut        <= pending_q;
            pendingValid_q <= 1'b0;
        end
    end

endmodule // dmr_result_latch

`default_nettype wire

// >>> testbench/dmr_bank_asserts.sv
// Port checker for the monitor readback bank.
`timescale 1ns/1ps
`default_nettype none
module dmr_bank_asserts #(
    parameter RESULT_W = 12,
    parameter SOURCES  = 6
) (
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                resultValid,
    input wire logic [3:0]          resultTag,
    input wire logic [RESULT_W-1:0] resultData,
    input wire logic                freezeResultUpdate,
    input wire logic                regRead,
    input wire logic                regWrite,
    input wire logic [7:0]          regAddr,
    input wire logic [7:0]          regWdata,
    input wire logic [7:0]          regRdata,
    input wire logic                regRvalid,
    input wire logic                regHit
);
    // ======================================================================
    // Properties
    wire logic       mapped = (regAddr >= 8'h5d) && (regAddr <= 8'h67);
    wire logic [7:0] tagOf  = (regAddr - 8'h5a) >> 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_cap2; resultValid && resultTag == 4'h2 && !freezeResultUpdate; endsequence
    sequence s_frzRd; freezeResultUpdate && regRead && regAddr == 8'h60; endsequence
    sequence s_join;
        regRead && regAddr == 8'h5e && !resultValid ##1 regRead && regAddr == 8'h5f;
    endsequence
    property p_ans; regRead |=> regRvalid; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_quiet; !regRead |=> !regRvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without read");
    property p_bias; regRead && regAddr == 8'h5d |=> regRdata[3:0] == 4'h1; endproperty
    a_bias: assert property (p_bias) else $error("bias tag wrong");
    property p_tag;
        regRead && mapped && regAddr[0] |=> {4'h0, regRdata[3:0]} == $past(tagOf);
    endproperty
    a_tag: assert property (p_tag) else $error("source tag wrong");
    property p_hit; regRead && mapped |=> regHit; endproperty
    a_hit: assert property (p_hit) else $error("mapped read not hit");
    property p_high;
        s_cap2 ##1 regRead && regAddr == 8'h5e |=> {4'h0, regRdata} == ($past(resultData, 2) >> 4);
    endproperty
    a_high: assert property (p_high) else $error("high byte wrong");
    property p_low;
        s_cap2 ##1 regRead && regAddr == 8'h5f
            |=> {8'h00, regRdata[7:4]} == ($past(resultData, 2) & 12'h00f);
    endproperty
    a_low: assert property (p_low) else $error("low nibble wrong");
    property p_hold; s_frzRd ##1 s_frzRd |=> regRdata == $past(regRdata); endproperty
    a_hold: assert property (p_hold) else $error("frozen value moved");
    property p_join;
        s_cap2 ##1 s_join |=> {$past(regRdata), regRdata[7:4]} == $past(resultData, 3);
    endproperty
    a_join: assert property (p_join) else $error("joined result wrong");
endmodule // dmr_bank_asserts
bind dmr_bank dmr_bank_asserts #(.RESULT_W(RESULT_W), .SOURCES(SOURCES)) u_chk (
    .clk(clk), .resetn(resetn), .resultValid(resultValid), .resultTag(resultTag),
    .resultData(resultData), .freezeResultUpdate(freezeResultUpdate), .regRead(regRead),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .regHit(regHit));
`default_nettype wire

// >>> testbench/dmr_bank_bench.sv
// Self-checking bench for the monitor readback bank.
`timescale 1ns/1ps
`default_nettype none
module dmr_bank_bench;
    logic        clk, resetn, resultValid, freezeResultUpdate, regRead, regWrite;
    logic [3:0]  resultTag;
    logic [11:0] resultData;
    logic [7:0]  regAddr, regWdata, regRdata;
    logic        regRvalid, regHit;
    logic [11:0] vis [1:6];
    logic [11:0] pend [1:6];
    logic [6:1]  pv;
    logic [8:0]  expQ [$];
    logic [8:0]  got;
    int          fails = 0;
    int          n_checks = 0;
    dmr_bank DUT (.clk(clk), .resetn(resetn), .resultValid(resultValid), .resultTag(resultTag),
        .resultData(resultData), .freezeResultUpdate(freezeResultUpdate), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .regRvalid(regRvalid), .regHit(regHit));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ======================================================================
    // Expected image and watcher
    function automatic logic [8:0] expv(input logic [7:0] a);
        logic [7:0] t;
        t = (a - 8'h5a) >> 1;
        if (a < 8'h5d || a > 8'h67) return 9'h000;
        return a[0] ? {1'b1, vis[t][3:0], t[3:0]} : {1'b1, vis[t][11:4]};
    endfunction
    always @(negedge clk) begin
        if (regRvalid === 1'b1) begin
            got = (expQ.size() > 0) ? expQ.pop_front() : 9'bx;
            n_checks++;
            if ({regHit, regRdata} !== got) begin
                fails++;
                $display("MISMATCH t=%0t got %h exp %h", $time, {regHit, regRdata}, got);
            end
        end
    end
    // Every op drives all request lines once, so no line is written twice in a step.
    task automatic op(input logic r, w, v, input logic [7:0] a, input logic [3:0] tg);
        logic [11:0] d;
        d = 12'($urandom);
        regRead = r;
        regWrite = w;
        resultValid = v;
        regAddr = a;
        regWdata = 8'($urandom);
        resultTag = tg;
        resultData = d;
        if (r) expQ.push_back(expv(a));
        if (v && tg >= 4'h1 && tg <= 4'h6) begin
            if (freezeResultUpdate) begin
                pend[tg] = d;
                pv[tg] = 1'b1;
            end else vis[tg] = d;
        end
        @(negedge clk);
    endtask
    task automatic sweep;
        for (int a = 8'h5b; a <= 8'h68; a++) op(1'b1, 1'b0, 1'b0, a[7:0], 4'h0);
        op(1'b0, 1'b0, 1'b0, 8'h00, 4'h0);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h399ac961));
        {resetn, freezeResultUpdate, regRead, regWrite, resultValid} = 5'h00;
        {regAddr, regWdata, resultTag, resultData, pv} = '0;
        for (int i = 1; i <= 6; i++) vis[i] = 12'h000;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        sweep();
        for (int t = 0; t < 8; t++) begin
            op(1'b0, 1'b0, 1'b1, 8'h00, t[3:0]);
            op(1'b1, 1'b0, 1'b0, 8'(8'h5a + 2 * t), 4'h0);
            op(1'b0, 1'b0, 1'b1, 8'h00, t[3:0]);
            op(1'b1, 1'b0, 1'b0, 8'(8'h5b + 2 * t), 4'h0);
        end
        // Fresh result, then high byte and low register back to back for joining.
        op(1'b0, 1'b0, 1'b1, 8'h00, 4'h2);
        op(1'b1, 1'b0, 1'b0, 8'h5e, 4'h0);
        op(1'b1, 1'b0, 1'b0, 8'h5f, 4'h0);
        for (int a = 8'h5b; a <= 8'h68; a++) op(1'b0, 1'b1, 1'b0, a[7:0], 4'h0);
        sweep();
        freezeResultUpdate = 1'b1;
        op(1'b0, 1'b0, 1'b0, 8'h00, 4'h0);
        for (int t = 1; t <= 6; t++) op(1'b0, 1'b0, 1'b1, 8'h00, t[3:0]);
        // A capture lands with the first read, so a leaky freeze shows on the second.
        op(1'b1, 1'b0, 1'b1, 8'h60, 4'h3);
        op(1'b1, 1'b0, 1'b0, 8'h60, 4'h0);
        freezeResultUpdate = 1'b0;
        for (int i = 1; i <= 6; i++) if (pv[i]) vis[i] = pend[i];
        pv = '0;
        repeat (3) op(1'b0, 1'b0, 1'b0, 8'h00, 4'h0);
        sweep();
        resetn = 1'b0;
        for (int i = 1; i <= 6; i++) vis[i] = 12'h000;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        sweep();
        for (int i = 0; i < 10 && expQ.size() > 0; i++) @(negedge clk);
        if (expQ.size() > 0) begin
            fails++;
            $display("MISMATCH t=%0t read never answered", $time);
        end
        conclude();
    end
endmodule // dmr_bank_bench
`default_nettype wire
